// ==== inc/hbi_pkg.sv ====
// Constants, types and timing figures shared by the host bus interface.
// Assumes the controller clock is clk and that one period of it is one
// controller clock period as seen by the host.
package hbi_pkg;

  localparam int          HBI_DATA_W          = 16;
  localparam int          HBI_ADDR_W          = 16;
  // Controller clock period in ns; one controller period is one clk cycle.
  localparam int          HBI_CLK_PERIOD_NS   = 4;
  localparam int          HBI_CC_PERIOD_NS    = 4;
  localparam int          HBI_CC_TO_CYC       =
    (HBI_CC_PERIOD_NS + HBI_CLK_PERIOD_NS - 1) / HBI_CLK_PERIOD_NS;
  // Host bus clock limits, in MHz and controller clock periods.
  localparam int          HBI_HOST_CLK_MAX_MHZ = 8;
  localparam int          HBI_STRETCH_PERIODS = 3;
  localparam int          HBI_LOW_MIN_CC      = 1;
  localparam int          HBI_HIGH_MIN_CC     = 4;
  localparam int          HBI_WR_HOLD_CC      = 3;
  localparam int          HBI_RD_MIN_CC       = 2;
  localparam int          HBI_RD_MAX_CC       = 3;
  localparam int          HBI_RD_MIN_CYC      = HBI_RD_MIN_CC * HBI_CC_TO_CYC;
  localparam int          HBI_RD_MAX_CYC      = HBI_RD_MAX_CC * HBI_CC_TO_CYC;
  // Synchroniser depth for pin inputs.
  localparam int          HBI_SYNC_STAGES     = 3;
  // Reset values.
  localparam logic        HBI_OE_N_RST        = 1'b1;
  localparam logic [15:0] HBI_DATA_RST        = 16'h0000;
  localparam logic        HBI_RW_READ         = 1'b1;

  typedef enum logic {
    HBI_MODE_ASYNC,
    HBI_MODE_SYNC
  } hbi_mode_t;

  typedef enum logic [1:0] {
    HBI_SB_IDLE,
    HBI_SB_READ,
    HBI_SB_WRITE
  } hbi_sb_state_t;

endpackage

// ==== design/hbi_sync3.sv ====
// Three-stage synchroniser for pin inputs entering the clk domain.
// Assumes each bit is either a slow level or is qualified by other logic.
module hbi_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] s2,
  output logic      [W-1:0] s3
);

  logic [W-1:0] s1_reg;

  // The first stage feeds only the second; a change counts in the cycle
  // where the second and third stages differ.
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= '0;
      s2     <= '0;
      s3     <= '0;
    end else begin
      s1_reg <= d;
      s2     <= s1_reg;
      s3     <= s2;
    end
  end

endmodule // hbi_sync3

// ==== design/hbi_host_port.sv ====
// Host port of the controller: asynchronous memory port and synchronous
// multiplexed host bus, both feeding one user-side access port.
// Assumes port_sel is a static strap and the host bus clock runs during rst.
module hbi_host_port
  import hbi_pkg::*;
#(
  parameter int AW = HBI_ADDR_W,
  parameter int DW = HBI_DATA_W
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          port_sel,
  input  wire logic          cs_n,
  input  wire logic          we_n,
  input  wire logic          oe_n,
  input  wire logic [AW-1:0] am_addr,
  input  wire logic [DW-1:0] am_data_in,
  output logic      [DW-1:0] am_data_out,
  output logic               am_data_oe_n,
  input  wire logic          host_bus_clock,
  input  wire logic          rw,
  input  wire logic          low_byte_strobe,
  input  wire logic [DW-1:0] ad_in,
  output logic      [DW-1:0] ad_out,
  output logic               ad_oe_n,
  output logic      [AW-1:0] usr_addr,
  output logic               usr_low_byte_strobe,
  output logic               usr_rd,
  output logic               usr_wr,
  output logic      [DW-1:0] usr_wdata,
  input  wire logic [DW-1:0] usr_rdata
);

  hbi_mode_t     mode_reg;
  hbi_sb_state_t sb_state_reg;

  // Link domain state, clocked by the host bus clock.
  logic          lrst1_reg;
  logic          lrst2_reg;
  logic [AW-1:0] lnk_addr_reg;
  logic          lnk_low_byte_strobe_reg;
  logic          lnk_rw_reg;
  logic          rise_tgl_reg;
  logic          fall_tgl_reg;

  // Controller domain.
  logic [1:0]       tgl_s2;
  logic [1:0]       tgl_s3;
  logic [2:0]       ctl_s3;
  logic [AW+DW-1:0] am_s3;
  logic [DW-1:0]    ad_s2;
  logic             wr_pend_reg;
  logic             rise_ev;
  logic             fall_ev;
  logic             am_cs_lo;
  logic             am_we_lo;
  logic             am_oe_lo;
  logic             am_wr_act;
  logic             am_rd_act;
  logic             am_wr_act_reg;
  logic             am_rd_act_reg;
  logic [AW-1:0]    am_addr_lat_reg;
  logic [DW-1:0]    am_data_lat_reg;
  logic [DW-1:0]    dout_reg;

  // Reset reaches the link domain through two flip-flops of its own.
  always_ff @(posedge host_bus_clock) begin
    lrst1_reg <= rst;
    lrst2_reg <= lrst1_reg;
  end

  // Address, strobe and direction are taken at the host bus clock rise.
  always_ff @(posedge host_bus_clock) begin
    if (lrst2_reg) begin
      lnk_addr_reg  <= '0;
      lnk_low_byte_strobe_reg <= 1'b0;
      lnk_rw_reg    <= HBI_RW_READ;
      rise_tgl_reg  <= 1'b0;
    end else begin
      lnk_addr_reg  <= ad_in[AW-1:0];
      lnk_low_byte_strobe_reg <= low_byte_strobe;
      lnk_rw_reg    <= rw;
      rise_tgl_reg  <= ~rise_tgl_reg;
    end
  end

  // The falling edge marks the end of the access window.
  always_ff @(negedge host_bus_clock) begin
    if (lrst2_reg) begin
      fall_tgl_reg <= 1'b0;
    end else begin
      fall_tgl_reg <= ~fall_tgl_reg;
    end
  end

  // One toggle per host clock edge; the host clock must stay slow enough
  // for every toggle to pass the synchroniser.
  hbi_sync3 #(.W(2)) u_tgl_sync (
    .clk (clk),
    .rst (rst),
    .d   ({rise_tgl_reg, fall_tgl_reg}),
    .s2  (tgl_s2),
    .s3  (tgl_s3)
  );

  // Strobes enter inverted so that the cleared synchroniser reads as idle
  // and no false write is seen right after reset.
  hbi_sync3 #(.W(3)) u_ctl_sync (
    .clk (clk),
    .rst (rst),
    .d   ({~cs_n, ~we_n, ~oe_n}),
    .s2  (),
    .s3  (ctl_s3)
  );

  hbi_sync3 #(.W(AW + DW)) u_am_sync (
    .clk (clk),
    .rst (rst),
    .d   ({am_addr, am_data_in}),
    .s2  (),
    .s3  (am_s3)
  );

  hbi_sync3 #(.W(DW)) u_ad_sync (
    .clk (clk),
    .rst (rst),
    .d   (ad_in),
    .s2  (ad_s2),
    .s3  ()
  );

  // A toggle event is seen in the cycle where stages two and three differ.
  assign rise_ev   = tgl_s2[1] ^ tgl_s3[1];
  assign fall_ev   = tgl_s2[0] ^ tgl_s3[0];

  assign am_cs_lo  = ctl_s3[2];
  assign am_we_lo  = ctl_s3[1];
  assign am_oe_lo  = ctl_s3[0];
  assign am_wr_act = am_cs_lo & am_we_lo;
  assign am_rd_act = am_cs_lo & am_oe_lo & ~am_we_lo;

  // The port selection strap is caught while reset is held.
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg <= port_sel ? HBI_MODE_SYNC : HBI_MODE_ASYNC;
    end
  end

  // Synchronous bus access sequencing.
  always_ff @(posedge clk) begin
    if (rst) begin
      sb_state_reg <= HBI_SB_IDLE;
    end else if (mode_reg != HBI_MODE_SYNC) begin
      sb_state_reg <= HBI_SB_IDLE;
    end else begin
      case (sb_state_reg)
        HBI_SB_IDLE: begin
          if (rise_ev) begin
            sb_state_reg <= (lnk_rw_reg == HBI_RW_READ) ? HBI_SB_READ
                                                         : HBI_SB_WRITE;
          end
        end
        HBI_SB_READ, HBI_SB_WRITE: begin
          // The high phase of at least four periods lets the access finish.
          if (fall_ev) begin
            sb_state_reg <= HBI_SB_IDLE;
          end
        end
        default: begin
          sb_state_reg <= HBI_SB_IDLE;
        end
      endcase
    end
  end

  // Async access tracking and write capture.
  always_ff @(posedge clk) begin
    if (rst) begin
      am_wr_act_reg   <= 1'b0;
      am_rd_act_reg   <= 1'b0;
      am_addr_lat_reg <= '0;
      am_data_lat_reg <= HBI_DATA_RST;
    end else begin
      am_wr_act_reg <= am_wr_act;
      am_rd_act_reg <= am_rd_act;
      if (am_wr_act || am_rd_act) begin
        am_addr_lat_reg <= am_s3[AW+DW-1:DW];
      end
      if (am_wr_act) begin
        am_data_lat_reg <= am_s3[DW-1:0];
      end
    end
  end

  // The shared pins still carry the address at the rise sample, so write
  // data is taken one clock after the rise event.
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
    end else begin
      wr_pend_reg <= (mode_reg == HBI_MODE_SYNC) &&
                     (sb_state_reg == HBI_SB_IDLE) && rise_ev &&
                     (lnk_rw_reg != HBI_RW_READ);
    end
  end

  // User-side access port.
  always_ff @(posedge clk) begin
    if (rst) begin
      usr_addr  <= '0;
      usr_low_byte_strobe <= 1'b0;
      usr_rd    <= 1'b0;
      usr_wr    <= 1'b0;
      usr_wdata <= HBI_DATA_RST;
    end else if (mode_reg == HBI_MODE_SYNC) begin
      // The link address is stable from the rise until the next rise.
      usr_addr  <= lnk_addr_reg;
      usr_low_byte_strobe <= lnk_low_byte_strobe_reg;
      usr_rd    <= (sb_state_reg == HBI_SB_IDLE) && rise_ev &&
                   (lnk_rw_reg == HBI_RW_READ);
      usr_wr    <= wr_pend_reg;
      if (wr_pend_reg) begin
        usr_wdata <= ad_s2;
      end
    end else begin
      usr_addr  <= am_rd_act ? am_s3[AW+DW-1:DW] : am_addr_lat_reg;
      usr_low_byte_strobe <= 1'b0;
      usr_rd    <= am_rd_act && !am_rd_act_reg;
      usr_wr    <= am_wr_act_reg && !am_wr_act;
      if (am_wr_act_reg && !am_wr_act) begin
        usr_wdata <= am_data_lat_reg;
      end
    end
  end

  // Read data follows the user port every cycle, whether or not an access is open.
  always_ff @(posedge clk) begin
    if (rst) begin
      dout_reg <= HBI_DATA_RST;
    end else begin
      dout_reg <= usr_rdata;
    end
  end

  assign am_data_out = dout_reg;
  assign ad_out      = dout_reg;

  // Async data pins float unless a read is open.
  always_ff @(posedge clk) begin
    if (rst) begin
      am_data_oe_n <= HBI_OE_N_RST;
    end else begin
      am_data_oe_n <= !(am_rd_act && (mode_reg == HBI_MODE_ASYNC));
    end
  end

  // Sync bus drive starts at the rise event and ends at the fall event,
  // each two to three controller clocks after its host clock edge.
  always_ff @(posedge clk) begin
    if (rst) begin
      ad_oe_n <= HBI_OE_N_RST;
    end else if (mode_reg != HBI_MODE_SYNC) begin
      ad_oe_n <= HBI_OE_N_RST;
    end else if (fall_ev) begin
      ad_oe_n <= HBI_OE_N_RST;
    end else if ((sb_state_reg == HBI_SB_IDLE) && rise_ev &&
                 (lnk_rw_reg == HBI_RW_READ)) begin
      ad_oe_n <= 1'b0;
    end
  end

endmodule // hbi_host_port

// ==== tb/hbi_host_port_monitor.sv ====
// Concurrent checks on the host port pins and its user-side strobes.
// Assumes the strap port_sel is steady while rst is high.
module hbi_host_port_monitor
  import hbi_pkg::*;
#(
  parameter int AW = HBI_ADDR_W,
  parameter int DW = HBI_DATA_W
) (
  input wire logic          clk,
  input wire logic          rst,
  input wire logic          port_sel,
  input wire logic          cs_n,
  input wire logic          we_n,
  input wire logic          oe_n,
  input wire logic          am_data_oe_n,
  input wire logic          host_bus_clock,
  input wire logic          rw,
  input wire logic          low_byte_strobe,
  input wire logic [DW-1:0] ad_in,
  input wire logic [DW-1:0] ad_out,
  input wire logic          ad_oe_n,
  input wire logic [AW-1:0] usr_addr,
  input wire logic          usr_low_byte_strobe,
  input wire logic          usr_rd,
  input wire logic          usr_wr,
  input wire logic [DW-1:0] usr_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic          sync_reg;
  logic [1:0]    hb_run_reg;
  logic [AW-1:0] cap_addr_reg;
  logic          cap_lsb_reg;

  always_ff @(posedge clk) begin
    if (rst) sync_reg <= port_sel;
  end

  always_ff @(posedge host_bus_clock) begin
    cap_addr_reg <= ad_in[AW-1:0];
    cap_lsb_reg  <= low_byte_strobe;
  end

  // The link side acts only from the third host clock rise after reset.
  always_ff @(posedge host_bus_clock) begin
    if (rst) begin
      hb_run_reg <= 2'h0;
    end else if (hb_run_reg != 2'h3) begin
      hb_run_reg <= hb_run_reg + 2'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence hb_rise;
    sync_reg && (hb_run_reg == 2'h3) && $rose(host_bus_clock);
  endsequence
  sequence wr_end;
    !sync_reg && $fell(!cs_n && !we_n);
  endsequence

  a_float_deselect:
    assert property ((!sync_reg && cs_n) [*5] |-> am_data_oe_n)
    else $error("Data pins driven while deselected.");
  a_float_write:
    assert property ((!sync_reg && !cs_n && !we_n) [*5] |-> am_data_oe_n)
    else $error("Data pins driven during a write.");
  a_drive_read:
    assert property ((!sync_reg && !cs_n && !oe_n && we_n) [*6]
      |-> !am_data_oe_n)
    else $error("Data pins not driven during a read.");
  a_write_commit:
    assert property (wr_end |-> ##[2:6] usr_wr)
    else $error("Write not committed after its end.");
  a_read_window:
    assert property (hb_rise ##0 rw |-> ##[1:4] ($fell(ad_oe_n) && usr_rd))
    else $error("Read data not presented in time.");
  a_write_event:
    assert property (hb_rise ##0 !rw |-> ##[1:4] usr_wr)
    else $error("Bus write not taken after clock rise.");
  a_close_fall:
    assert property (sync_reg && $fell(host_bus_clock) && !ad_oe_n
      |-> ##[1:4] ad_oe_n)
    else $error("Bus not released after clock fall.");
  a_capture_addr:
    assert property (sync_reg && (usr_wr || usr_rd)
      |-> usr_addr == cap_addr_reg && usr_low_byte_strobe == cap_lsb_reg)
    else $error("Address or strobe not those of the clock rise.");
  a_read_data:
    assert property (!ad_oe_n |-> ad_out == $past(usr_rdata))
    else $error("Read data differs from the user data.");
endmodule // hbi_host_port_monitor

bind hbi_host_port hbi_host_port_monitor #(.AW(AW), .DW(DW)) mon_inst (.*);

// ==== tb/hbi_host_model.sv ====
// Host bus controller model: runs the host bus clock and makes accesses.
// Assumes the bench calls access only when the previous one has returned.
module hbi_host_model (
  output logic              host_bus_clock,
  output logic              rw,
  output logic              low_byte_strobe,
  output logic [15:0]       ad_in,
  input  wire logic [15:0]  ad_out,
  input  wire logic         ad_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;

  // A 160 ns period, even phases, well inside the limits.
  initial begin
    host_bus_clock = 1'b0;
    rw = 1'b1;
    low_byte_strobe = 1'b0;
    ad_in = 16'h5a5a;
    #1.7;
    forever #80 host_bus_clock = ~host_bus_clock;
  end

  task automatic access(input logic wr, input logic lsb,
                        input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic oe);
    @(negedge host_bus_clock);
    #2 rw = ~wr;
    low_byte_strobe = lsb;
    ad_in = a;
    @(posedge host_bus_clock);
    // Released bus during a read shows a changing pattern.
    #2 ad_in = wr ? d : ~a;
    #40 q = ad_out;
    oe = ad_oe_n;
    @(negedge host_bus_clock);
    #2 ad_in = ~ad_in;
    // Idle bus cycles between accesses are reads, never repeated writes.
    rw = 1'b1;
  endtask
endmodule // hbi_host_model

// ==== tb/hbi_host_port_tb.sv ====
// Self-checking bench of the host port in both strap modes.
// Pins change at the falling clk edge; the host model runs the bus.
module hbi_host_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst, port_sel, cs_n, we_n, oe_n, oe, usr_rd, usr_wr;
  logic        am_data_oe_n, ad_oe_n, usr_low_byte_strobe, host_bus_clock, rw;
  logic        low_byte_strobe;
  logic [15:0] am_addr, am_data_in, am_data_out, ad_out, ad_in, q;
  logic [15:0] usr_addr, usr_wdata, usr_rdata;
  logic [15:0] umem [256];
  logic [15:0] rmem [256];
  logic [32:0] wq   [$];
  int          error_cnt, samples_checked;

  hbi_host_port hbi_host_port_inst (.*);
  hbi_host_model hbi_host_model_inst (.*);
  assign usr_rdata = umem[usr_addr[7:0]];

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(string nm, logic [32:0] seen, logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // User side: each commit must match the oldest write issued.
  always @(negedge clk) begin
    if (usr_wr === 1'b1) begin
      chk("usr_write", {usr_low_byte_strobe, usr_addr, usr_wdata}, wq.pop_front());
      umem[usr_addr[7:0]] = usr_wdata;
    end
  end

  task automatic do_reset(logic m);
    @(negedge clk);
    rst = 1'b1;
    port_sel = m;
    repeat (130) @(negedge clk);
    chk("oe_n_pair", {ad_oe_n, am_data_oe_n}, 2'b11);
    rst = 1'b0;
    // The link side acts only from the third host clock rise after reset.
    repeat (3) @(posedge host_bus_clock);
    repeat (4) @(negedge clk);
  endtask

  task automatic am_write(logic [15:0] a, logic [15:0] d, logic v);
    @(negedge clk);
    am_addr = a;
    am_data_in = ~d;
    {cs_n, we_n, oe_n} = {2'b00, ~v};
    wq.push_back({1'b0, a, d});
    rmem[a[7:0]] = d;
    repeat (4) @(negedge clk);
    am_data_in = d;
    repeat (4) @(negedge clk);
    chk("am_data_oe_n", am_data_oe_n, 1'b1);
    if (v) cs_n = 1'b1;
    else we_n = 1'b1;
    repeat (4) @(negedge clk);
    {cs_n, we_n, oe_n} = 3'b111;
    repeat (8) @(negedge clk);
  endtask

  task automatic am_read(logic [15:0] a);
    @(negedge clk);
    am_addr = a;
    {cs_n, oe_n} = 2'b00;
    repeat (8) @(negedge clk);
    chk("am_data_oe_n", am_data_oe_n, 1'b0);
    chk("am_data_out", am_data_out, rmem[a[7:0]]);
    oe_n = 1'b1;
    repeat (5) @(negedge clk);
    chk("am_data_oe_n", am_data_oe_n, 1'b1);
    cs_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  task automatic sb_access(logic wr, logic [15:0] a, logic [15:0] d);
    logic l;
    l = 1'($urandom);
    if (wr) wq.push_back({l, a, d});
    if (wr) rmem[a[7:0]] = d;
    hbi_host_model_inst.access(wr, l, a, d, q, oe);
    if (!wr) chk("ad_oe_n", oe, 1'b0);
    if (!wr) chk("ad_out", q, rmem[a[7:0]]);
  endtask

  task automatic complete_run();
    if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    error_cnt++;
    complete_run();
  end

  initial begin
    {rst, port_sel, cs_n, we_n, oe_n} = 5'b10111;
    am_addr = 16'h0000;
    am_data_in = 16'h0000;
    error_cnt = 0;
    samples_checked = 0;
    foreach (umem[k]) {umem[k], rmem[k]} = 32'h0000_0000;
    void'($urandom(77340));
    do_reset(1'b0);
    for (int i = 0; i < 6; i++) begin
      am_write({8'($urandom), 4'(i), 4'h3}, 16'($urandom), i[0]);
      am_read({8'($urandom), 4'(i), 4'h3});
    end
    do_reset(1'b1);
    for (int i = 0; i < 6; i++) begin
      sb_access(1'b1, {8'($urandom), 4'(i), 4'h9}, 16'($urandom));
      sb_access(1'b0, {8'($urandom), 4'(i), 4'h9}, 16'h0000);
    end
    sb_access(1'b0, 16'h0003, 16'h0000);
    chk("write_queue", 33'(wq.size()), 33'h0);
    complete_run();
  end
endmodule // hbi_host_port_tb
